/* File: dac_ctrl_pkg.sv */
// Shared constants and types for the serial program register bank
package dac_ctrl_pkg;

  localparam int WORD_BITS = 16;
  // Word layout
  localparam int ADDR_HI = 10;
  localparam int ADDR_LO = 9;
  localparam int LOAD_BIT = 8;
  localparam int LEVEL_HI = 7;
  localparam int RSV_HI = 15;
  localparam int RSV_LO = 11;
  // Register addresses
  localparam logic [1:0] ADDR_LEFT = 2'h0;
  localparam logic [1:0] ADDR_RIGHT = 2'h1;
  localparam logic [1:0] ADDR_OUTWORD = 2'h2;
  localparam logic [1:0] ADDR_FMTRATE = 2'h3;
  // Field positions, output and word control
  localparam int MUTE_POS = 0;
  localparam int DEEMPH_POS = 1;
  localparam int OPCTL_POS = 2;
  localparam int IWIDTH_LO = 3;
  localparam int CHMODE_LO = 5;
  // Field positions, format and rate control
  localparam int FORMAT_POS = 0;
  localparam int POLARITY_POS = 1;
  localparam int COMMON_POS = 2;
  localparam int DRATE_LO = 4;
  localparam int GROUP_LO = 6;
  localparam int ZDET_POS = 8;
  // Reset values
  localparam logic [7:0] LEVEL_RESET = 8'hff;
  localparam logic [3:0] CHMODE_STEREO = 4'h9;
  localparam logic [1:0] IWIDTH_RESET = 2'h0;
  localparam logic [1:0] DRATE_RESET = 2'h0;
  localparam logic [1:0] GROUP_RESET = 2'h0;
  // Field encodings
  localparam logic [1:0] IWIDTH_16 = 2'h0;
  localparam logic [1:0] IWIDTH_20 = 2'h1;
  localparam logic [1:0] IWIDTH_24 = 2'h2;
  localparam logic [1:0] DRATE_NORMAL = 2'h0;
  localparam logic [1:0] DRATE_DOUBLE = 2'h1;
  localparam logic [1:0] GROUP_44K1 = 2'h0;
  localparam logic [4:0] WIDTH_16 = 5'h10;
  localparam logic [4:0] WIDTH_20 = 5'h14;
  localparam logic [4:0] WIDTH_24 = 5'h18;
  // Clock plan, in Hz except the CORE_MULT multiple
  localparam logic [31:0] REF_HZ = 32'd27000000;
  localparam logic [31:0] FS_44K1_HZ = 32'd44100;
  localparam logic [31:0] FS_48K_HZ = 32'd48000;
  localparam logic [31:0] FS_96K_HZ = 32'd96000;
  localparam logic [31:0] CORE_MULT = 32'd384;
  localparam logic [31:0] CK2_44K1_HZ = 32'd16934400;
  localparam logic [31:0] CK3_44K1_HZ = 32'd33868800;
  localparam logic [31:0] CK2_48K_HZ = 32'd18432000;
  localparam logic [31:0] CK3_48K_HZ = 32'd36864000;
  localparam logic [31:0] CK_96K_HZ = 32'd36864000;

  typedef enum logic [1:0] {RATE_44K1, RATE_48K, RATE_96K} rate_t;

  // Settings applied to the converter
  typedef struct packed {
    logic [7:0] leftLevel;
    logic [7:0] rightLevel;
    logic softMute;
    logic deemphasisEnable;
    logic operationControl;
    logic [1:0] inputWidthSelect;
    logic [3:0] outputChannelMode;
    logic i2sFormat;
    logic wordClockPolarity;
    logic commonAttenuation;
    logic [1:0] doubleRateSelect;
    logic [1:0] samplingGroupSelect;
    logic zeroDetectEnable;
  } dac_config_t;

  // Decoded clock plan
  typedef struct packed {
    rate_t rate;
    logic [4:0] wordBits;
    logic widthReserved;
    logic rateReserved;
    logic [31:0] samplingHz;
    logic [31:0] clockTwoHz;
    logic [31:0] clockThreeHz;
    logic [31:0] coreClockHz;
  } clock_plan_t;

endpackage : dac_ctrl_pkg

/* File: dac_serial_control_registers.sv */
// Three-wire program port and program register bank of the stereo converter
`timescale 1ns/1ps
`default_nettype none

module dac_serial_control_registers
  import dac_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic programShiftClock,
  input wire logic programDataLine,
  input wire logic programLatchStrobe,
  output dac_config_t applied,
  output clock_plan_t clockPlan,
  output logic wordCommitted
);

  // Link domain: shifter on the program clock
  logic [WORD_BITS-1:0] shiftWord;

  // MSB first shift
  // Extra bits fall off the top; only the last sixteen count
  always_ff @(posedge programShiftClock or negedge rstn) begin
    if (!rstn) begin
      shiftWord <= '0;
    end else begin
      shiftWord <= {shiftWord[WORD_BITS-2:0], programDataLine};
    end
  end

  // Core domain: strobe synchroniser and edge detect
  logic strobeMeta;
  logic strobeSync;
  logic strobeLast;
  logic commit;

  // strobe crossing, only the second flop is read onward
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strobeMeta <= 1'b0;
      strobeSync <= 1'b0;
    end else begin
      strobeMeta <= programLatchStrobe;
      strobeSync <= strobeMeta;
    end
  end

  // Reset level equals the idle low strobe, so no false edge after reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strobeLast <= 1'b0;
    end else begin
      strobeLast <= strobeSync;
    end
  end

  // Shift clock is idle while the strobe is high, so the word is stable here
  assign commit = strobeSync & ~strobeLast;

  logic [WORD_BITS-1:0] word;
  logic [1:0] wordAddr;
  assign word = shiftWord;
  assign wordAddr = word[ADDR_HI:ADDR_LO];

  // one write enable per register, so a word touches only its target
  logic writeLeft;
  logic writeRight;
  logic writeOutWord;
  logic writeFmtRate;
  assign writeLeft = commit && (wordAddr == ADDR_LEFT);
  assign writeRight = commit && (wordAddr == ADDR_RIGHT);
  assign writeOutWord = commit && (wordAddr == ADDR_OUTWORD);
  assign writeFmtRate = commit && (wordAddr == ADDR_FMTRATE);

  // Stored register images
  // Stored levels mirror the write-only image; only the load bit (LOAD_BIT) of the word moves the applied copy
  logic [7:0] leftStored;
  logic [7:0] rightStored;
  logic [7:0] leftApplied;
  logic [7:0] rightApplied;
  logic [WORD_BITS-1:0] outWordReg;
  logic [WORD_BITS-1:0] fmtRateReg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      leftStored <= LEVEL_RESET;
      leftApplied <= LEVEL_RESET;
    end else if (writeLeft) begin
      leftStored <= word[LEVEL_HI:0];
      if (word[LOAD_BIT]) begin
        leftApplied <= word[LEVEL_HI:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rightStored <= LEVEL_RESET;
      rightApplied <= LEVEL_RESET;
    end else if (writeRight) begin
      rightStored <= word[LEVEL_HI:0];
      if (word[LOAD_BIT]) begin
        rightApplied <= word[LEVEL_HI:0];
      end
    end
  end

  localparam logic [WORD_BITS-1:0] OUTWORD_RESET =
    WORD_BITS'({CHMODE_STEREO, IWIDTH_RESET, 3'h0} << 0);
  localparam logic [WORD_BITS-1:0] FMTRATE_RESET =
    WORD_BITS'({1'b0, GROUP_RESET, DRATE_RESET, 4'h0});

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outWordReg <= OUTWORD_RESET;
    end else if (writeOutWord) begin
      outWordReg <= {5'h00, word[RSV_LO-1:0]};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fmtRateReg <= FMTRATE_RESET;
    end else if (writeFmtRate) begin
      fmtRateReg <= {5'h00, word[RSV_LO-1:0]};
    end
  end

  // Field extraction; reserved bit three of the format image is never read
  logic muteOn;
  logic deemphOn;
  logic opCtl;
  logic [1:0] iwidth;
  logic [3:0] chMode;
  logic i2sOn;
  logic polarityOn;
  logic commonOn;
  logic [1:0] drate;
  logic [1:0] group;
  logic zeroDetOn;
  assign muteOn = outWordReg[MUTE_POS];
  assign deemphOn = outWordReg[DEEMPH_POS];
  assign opCtl = outWordReg[OPCTL_POS];
  assign iwidth = outWordReg[IWIDTH_LO+1:IWIDTH_LO];
  assign chMode = outWordReg[CHMODE_LO+3:CHMODE_LO];
  assign i2sOn = fmtRateReg[FORMAT_POS];
  assign polarityOn = fmtRateReg[POLARITY_POS];
  assign commonOn = fmtRateReg[COMMON_POS];
  assign drate = fmtRateReg[DRATE_LO+1:DRATE_LO];
  assign group = fmtRateReg[GROUP_LO+1:GROUP_LO];
  assign zeroDetOn = fmtRateReg[ZDET_POS];

  // defaults reach the outputs straight from reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      applied.leftLevel <= LEVEL_RESET;
      applied.rightLevel <= LEVEL_RESET;
      applied.softMute <= 1'b0;
      applied.deemphasisEnable <= 1'b0;
      applied.operationControl <= 1'b0;
      applied.inputWidthSelect <= IWIDTH_RESET;
      applied.outputChannelMode <= CHMODE_STEREO;
      applied.i2sFormat <= 1'b0;
      applied.wordClockPolarity <= 1'b0;
      applied.commonAttenuation <= 1'b0;
      applied.doubleRateSelect <= DRATE_RESET;
      applied.samplingGroupSelect <= GROUP_RESET;
      applied.zeroDetectEnable <= 1'b0;
    end else begin
      applied.leftLevel <= leftApplied;
      applied.rightLevel <= commonOn ? leftApplied : rightApplied;
      applied.softMute <= muteOn;
      applied.deemphasisEnable <= deemphOn;
      applied.operationControl <= opCtl;
      applied.inputWidthSelect <= iwidth;
      applied.outputChannelMode <= chMode;
      applied.i2sFormat <= i2sOn;
      applied.wordClockPolarity <= polarityOn;
      applied.commonAttenuation <= commonOn;
      applied.doubleRateSelect <= drate;
      applied.samplingGroupSelect <= group;
      applied.zeroDetectEnable <= zeroDetOn;
    end
  end

  // rate selection; reserved rate codes fall back to standard
  rate_t next_rate;
  always_comb begin
    if (drate == DRATE_DOUBLE) begin
      next_rate = RATE_96K;
    end else if (group == GROUP_44K1) begin
      next_rate = RATE_44K1;
    end else begin
      next_rate = RATE_48K;
    end
  end

  // width decode; reserved code keeps 16-bit framing
  logic [4:0] next_wordBits;
  always_comb begin
    case (iwidth)
      IWIDTH_16: next_wordBits = WIDTH_16;
      IWIDTH_20: next_wordBits = WIDTH_20;
      IWIDTH_24: next_wordBits = WIDTH_24;
      default: next_wordBits = WIDTH_16;
    endcase
  end

  logic [31:0] next_fs;
  logic [31:0] next_ck2;
  logic [31:0] next_ck3;
  always_comb begin
    case (next_rate)
      RATE_44K1: begin
        next_fs = FS_44K1_HZ;
        next_ck2 = CK2_44K1_HZ;
        next_ck3 = CK3_44K1_HZ;
      end
      RATE_48K: begin
        next_fs = FS_48K_HZ;
        next_ck2 = CK2_48K_HZ;
        next_ck3 = CK3_48K_HZ;
      end
      RATE_96K: begin
        next_fs = FS_96K_HZ;
        next_ck2 = CK_96K_HZ;
        next_ck3 = CK_96K_HZ;
      end
      default: begin
        next_fs = FS_44K1_HZ;
        next_ck2 = CK2_44K1_HZ;
        next_ck3 = CK3_44K1_HZ;
      end
    endcase
  end

  // core clock multiple, used only while below twice the reference, else clock two
  logic [31:0] next_core;
  assign next_core = 32'(next_fs * CORE_MULT);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clockPlan.rate <= RATE_44K1;
      clockPlan.wordBits <= WIDTH_16;
      clockPlan.widthReserved <= 1'b0;
      clockPlan.rateReserved <= 1'b0;
      clockPlan.samplingHz <= FS_44K1_HZ;
      clockPlan.clockTwoHz <= CK2_44K1_HZ;
      clockPlan.clockThreeHz <= CK3_44K1_HZ;
      clockPlan.coreClockHz <= CK2_44K1_HZ;
    end else begin
      clockPlan.rate <= next_rate;
      clockPlan.wordBits <= next_wordBits;
      clockPlan.widthReserved <= (iwidth == 2'h3);
      clockPlan.rateReserved <= (drate != DRATE_NORMAL) && (drate != DRATE_DOUBLE);
      clockPlan.samplingHz <= next_fs;
      clockPlan.clockTwoHz <= next_ck2;
      clockPlan.clockThreeHz <= next_ck3;
      clockPlan.coreClockHz <= (next_core < REF_HZ * 2) ? next_core : next_ck2;
    end
  end

  // One-cycle mark of each stored word
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wordCommitted <= 1'b0;
    end else begin
      wordCommitted <= commit;
    end
  end

endmodule : dac_serial_control_registers
`default_nettype wire

/* File: dac_ctrl_assertions.sv */
// Timing and decode checks on the program register bank ports
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_assertions
  import dac_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic programShiftClock,
  input wire logic programDataLine,
  input wire logic programLatchStrobe,
  input wire dac_config_t applied,
  input wire clock_plan_t clockPlan,
  input wire logic wordCommitted
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_commit_late: assert property (
    $rose(programLatchStrobe) |-> ##[2:3] wordCommitted)
    else $error("word not committed in time");
  a_commit_pulse: assert property (
    wordCommitted |=> !wordCommitted)
    else $error("commit pulse too long");
  a_commit_cause: assert property (
    wordCommitted |-> $past(programLatchStrobe, 2))
    else $error("commit without strobe");
  a_applied_hold: assert property (
    !$past(wordCommitted) |-> $stable(applied))
    else $error("settings moved without a word");
  a_plan_hold: assert property (
    !$past(wordCommitted) |-> $stable(clockPlan))
    else $error("clock plan moved without a word");
  a_common_level: assert property (
    applied.commonAttenuation |-> applied.rightLevel == applied.leftLevel)
    else $error("common level not shared");
  a_core_mult: assert property (
    clockPlan.coreClockHz == CORE_MULT * clockPlan.samplingHz)
    else $error("core clock not 384 fs");
  a_double_rate: assert property (
    applied.doubleRateSelect == DRATE_DOUBLE |->
      clockPlan.rate == RATE_96K && clockPlan.clockTwoHz == CK_96K_HZ)
    else $error("double rate not decoded");
  a_width_twenty: assert property (
    applied.inputWidthSelect == IWIDTH_20 |-> clockPlan.wordBits == WIDTH_20)
    else $error("width code one not 20 bits");
endmodule : dac_ctrl_assertions
`default_nettype wire

/* File: host_port_model.sv */
// Host side of the three-wire program port
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  output logic shiftClk,
  output logic dataLine,
  output logic strobe
);
  initial begin
    shiftClk = 1'b0;
    dataLine = 1'b0;
    strobe = 1'b0;
  end

  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      dataLine = w[i];
      #3 shiftClk = 1'b1;
      #3 shiftClk = 1'b0;
    end
    // Released line must not mimic held data
    dataLine = ~w[0];
    // strobe after sixteen bits
    // Strobe lands mid-cycle of the core clock, clear of its sampling edge
    #53 strobe = 1'b1;
    #400 strobe = 1'b0;
    #400;
  endtask : send_word
endmodule : host_port_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the program register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dac_ctrl_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic shiftClk;
  logic dataLine;
  logic strobe;
  dac_config_t applied;
  clock_plan_t clockPlan;
  logic wordCommitted;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int commits = 0;

  always #50 core_clk = ~core_clk;

  dac_serial_control_registers i_dac_serial_control_registers (
    .core_clk(core_clk), .rstn(rstn), .programShiftClock(shiftClk),
    .programDataLine(dataLine), .programLatchStrobe(strobe),
    .applied(applied), .clockPlan(clockPlan), .wordCommitted(wordCommitted));
  host_port_model i_host_port_model (
    .shiftClk(shiftClk), .dataLine(dataLine), .strobe(strobe));

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wordCommitted === 1'b1) begin
      commits <= commits + 1;
    end
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic put(input logic [1:0] a, input logic [8:0] d, input logic [4:0] r = 5'h00);
    int c0;
    @(posedge core_clk);
    #1;
    c0 = commits;
    i_host_port_model.send_word({r, a, d});
    check(32'(commits - c0), 32'h1);
  endtask : put

  task automatic do_reset();
    @(posedge core_clk);
    #1;
    rstn = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    rstn = 1'b1;
  endtask : do_reset

  task automatic t_defaults();
    check({applied.leftLevel, applied.rightLevel}, 16'hffff);
    check({applied.softMute, applied.deemphasisEnable, applied.operationControl}, 0);
    check(applied.inputWidthSelect, IWIDTH_16);
    check(applied.outputChannelMode, CHMODE_STEREO);
    check({applied.i2sFormat, applied.wordClockPolarity, applied.commonAttenuation,
           applied.zeroDetectEnable, applied.doubleRateSelect,
           applied.samplingGroupSelect}, 0);
    check(clockPlan.clockTwoHz, CK2_44K1_HZ);
    check(clockPlan.wordBits, WIDTH_16);
  endtask : t_defaults

  task automatic t_levels();
    put(ADDR_LEFT, 9'h040);
    check(applied.leftLevel, 8'hff);
    put(ADDR_LEFT, 9'h140);
    check(applied.leftLevel, 8'h40);
    put(ADDR_RIGHT, 9'h1a5);
    check(applied.rightLevel, 8'ha5);
    check(applied.leftLevel, 8'h40);
  endtask : t_levels

  task automatic t_reserved();
    put(ADDR_OUTWORD, 9'h1d3, 5'h1f);
    check(applied.outputChannelMode, 4'he);
    check(applied.inputWidthSelect, IWIDTH_24);
    check({applied.softMute, applied.deemphasisEnable, applied.operationControl}, 3'h6);
    check(applied.rightLevel, 8'ha5);
  endtask : t_reserved

  task automatic t_widths();
    logic [4:0] exp [4] = '{WIDTH_16, WIDTH_20, WIDTH_24, WIDTH_16};
    for (int i = 0; i < 4; i++) begin
      put(ADDR_OUTWORD, {4'h9, i[1:0], 3'h4});
      check(clockPlan.wordBits, exp[i]);
      check(clockPlan.widthReserved, i == 3);
      check(applied.operationControl, 1'b1);
    end
  endtask : t_widths

  task automatic t_rates();
    logic [3:0] code [4] = '{4'h0, 4'h4, 4'h1, 4'h2};
    logic [31:0] two [4] = '{CK2_44K1_HZ, CK2_48K_HZ, CK_96K_HZ, CK2_44K1_HZ};
    logic [31:0] three [4] = '{CK3_44K1_HZ, CK3_48K_HZ, CK_96K_HZ, CK3_44K1_HZ};
    logic [31:0] fs [4] = '{FS_44K1_HZ, FS_48K_HZ, FS_96K_HZ, FS_44K1_HZ};
    rate_t rt [4] = '{RATE_44K1, RATE_48K, RATE_96K, RATE_44K1};
    for (int i = 0; i < 4; i++) begin
      put(ADDR_FMTRATE, {1'b1, code[i], 4'h7});
      check(clockPlan.clockTwoHz, two[i]);
      check(clockPlan.clockThreeHz, three[i]);
      check(clockPlan.rateReserved, i == 3);
      check(clockPlan.samplingHz, fs[i]);
      check(clockPlan.rate, rt[i]);
      check(clockPlan.coreClockHz, two[i]);
      check({applied.samplingGroupSelect, applied.doubleRateSelect}, code[i]);
    end
    check({applied.i2sFormat, applied.wordClockPolarity, applied.commonAttenuation,
           applied.zeroDetectEnable}, 4'hf);
    check(applied.rightLevel, 8'h40);
  endtask : t_rates

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    t_defaults();
    t_levels();
    t_reserved();
    t_widths();
    t_rates();
    do_reset();
    t_defaults();
    final_report();
  end
endmodule : tb_top

bind dac_serial_control_registers dac_ctrl_assertions i_dac_ctrl_assertions (
  .core_clk(core_clk), .rstn(rstn), .programShiftClock(programShiftClock),
  .programDataLine(programDataLine), .programLatchStrobe(programLatchStrobe),
  .applied(applied), .clockPlan(clockPlan), .wordCommitted(wordCommitted));
`default_nettype wire
